//--- logic/jump_target_calc.sv
// combinational decode, link value and target formation for the jumps
`timescale 1ns/1ps
`default_nettype none
module jump_target_calc
  import link_jump_pkg::*;
(
  // instruction context
  input  wire logic [31:0] instr,
  input  wire logic [31:0] jump_pc,
  input  wire logic [31:0] src_val,
  input  wire logic        isa_now,
  // core configuration
  input  wire logic        dual_isa,
  // result
  output jump_calc_t       calc
);

  logic [5:0]  major;
  logic [9:0]  minor;
  logic [5:0]  sub;
  logic [31:0] slot_pc;

  assign major   = instr[MAJOR_HI:MAJOR_LO];
  assign minor   = instr[MINOR_HI:MINOR_LO];
  assign sub     = instr[SUB_HI:SUB_LO];
  assign slot_pc = jump_pc + SLOT_STEP;

  // decode, link value and target
  always_comb begin
    calc          = '0;
    calc.kind     = KIND_NONE;
    calc.link_idx = instr[LINK_HI:LINK_LO];
    calc.isa_sel  = isa_now;
    calc.link_val = jump_pc + LINK_STEP;
    if (major == major_pool_a && sub == sub_pool_axf) begin
      if (minor == minor_reg_link_jump) begin
        calc.kind = KIND_REG;
      end
      if (minor == minor_reg_link_barrier) begin
        calc.kind = KIND_BARRIER;
      end
    end
    if (major == region_link_jump_opcode) begin
      calc.kind     = KIND_REGION;
      calc.link_idx = GEN_REG_RETURN;
      calc.target   = {slot_pc[31:REGION_LO], instr[INDEX_HI:0], 1'b0};
    end
    if (calc.kind == KIND_REG || calc.kind == KIND_BARRIER) begin
      // flag encodings the program must avoid
      calc.same_reg = (instr[SRC_HI:SRC_LO] == instr[LINK_HI:LINK_LO]);
      // bit 0 cleared, mode from bit 0 on a dual-set core, compact set otherwise
      calc.target   = {src_val[31:1], 1'b0};
      calc.isa_sel  = dual_isa ? src_val[0] : 1'b1;
      // 32-bit mode target not word aligned
      // 32-bit mode absent on this core
      calc.addr_err = dual_isa ? (~src_val[0] & src_val[1]) : ~src_val[0];
    end
  end

endmodule
`default_nettype wire

//--- logic/link_jump_pkg.sv
// shared constants, types and decode layout for the short-slot link jump unit
package link_jump_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_INSTR    = 8'h04;
  localparam logic [7:0] OFS_JUMP_PC  = 8'h08;
  localparam logic [7:0] OFS_SRC_VAL  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_LINK_VAL = 8'h14;
  localparam logic [7:0] OFS_TARGET   = 8'h18;
  localparam logic [7:0] OFS_RESUME   = 8'h1C;

  // control register bits
  localparam int CTRL_START    = 0;
  localparam int CTRL_DUAL_ISA = 1;
  localparam int CTRL_SLOT_OK  = 2;
  localparam int CTRL_SLOT_EXC = 3;
  localparam int CTRL_CLR_BAD  = 4;

  // status register bits
  localparam int ST_STATE_LO  = 0;
  localparam int ST_KIND_LO   = 2;
  localparam int ST_ISA       = 4;
  localparam int ST_ADDR_ERR  = 5;
  localparam int ST_HZ_EXEC   = 6;
  localparam int ST_HZ_INSTR  = 7;
  localparam int ST_BAD_OP    = 8;
  localparam int ST_SAME_REG  = 9;
  localparam int ST_RESUMABLE = 10;
  localparam int ST_LINK_LO   = 16;

  // instruction field layout
  localparam int MAJOR_HI = 31;
  localparam int MAJOR_LO = 26;
  localparam int LINK_HI  = 25;
  localparam int LINK_LO  = 21;
  localparam int SRC_HI   = 20;
  localparam int SRC_LO   = 16;
  localparam int MINOR_HI = 15;
  localparam int MINOR_LO = 6;
  localparam int SUB_HI   = 5;
  localparam int SUB_LO   = 0;
  localparam int INDEX_HI = 25;
  localparam int REGION_LO = 27;

  // opcode values
  localparam logic [5:0] major_pool_a            = 6'h00;
  localparam logic [5:0] sub_pool_axf            = 6'h3C;
  localparam logic [9:0] minor_reg_link_jump     = 10'h13C;
  localparam logic [9:0] minor_reg_link_barrier  = 10'h17C;
  localparam logic [5:0] region_link_jump_opcode = 6'h1D;

  // address arithmetic
  localparam logic [31:0] LINK_STEP      = 32'h0000_0006;
  localparam logic [31:0] SLOT_STEP      = 32'h0000_0004;
  localparam logic [4:0]  GEN_REG_RETURN = 5'h1F;
  localparam logic [31:0] RESET_ADDR     = 32'h0000_0000;

  // decoded jump kind
  typedef enum logic [1:0] {
    KIND_NONE    = 2'h0,
    KIND_REG     = 2'h1,
    KIND_BARRIER = 2'h2,
    KIND_REGION  = 2'h3
  } jump_kind_t;

  // sequencer states, gray along idle-slot-transfer
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SLOT = 2'h1,
    ST_XFER = 2'h3
  } seq_state_t;

  // decode result carried from the calculator
  typedef struct packed {
    jump_kind_t  kind;
    logic [4:0]  link_idx;
    logic        same_reg;
    logic [31:0] link_val;
    logic [31:0] target;
    logic        isa_sel;
    logic        addr_err;
  } jump_calc_t;

  // general register write port bundle
  typedef struct packed {
    logic        en;
    logic [4:0]  idx;
    logic [31:0] data;
  } gpr_write_t;

endpackage

//--- logic/short_slot_link_jump_unit.sv
// short-slot link jump unit: apb registers, sequencer, hazard tracking
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module short_slot_link_jump_unit
  import link_jump_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // hazard creating events from the core
  input  wire logic        hazard_exec_evt,
  input  wire logic        hazard_instr_evt,
  // general register write
  output logic             gpr_wr_en,
  output logic [4:0]       gpr_wr_idx,
  output logic [31:0]      gpr_wr_data,
  // fetch redirect
  output logic             pc_load,
  output logic [31:0]      pc_next,
  output logic             isa_select_bit,
  output logic             fetch_addr_err,
  output logic             hazard_clear
);

  // register state
  logic [31:0] instr_ff, nxt_instr;
  logic [31:0] jump_pc_ff, nxt_jump_pc;
  logic [31:0] src_val_ff, nxt_src_val;
  logic        dual_isa_ff, nxt_dual_isa;
  logic [31:0] resume_ff, nxt_resume;
  logic        bad_op_ff, nxt_bad_op;
  logic        resumable_ff, nxt_resumable;
  // sequencer state
  seq_state_t  state_ff, nxt_state;
  jump_calc_t  held_ff, nxt_held;
  // hazards pending before the jump and raised inside its slot
  logic [1:0]  hz_old_ff, nxt_hz_old;
  logic [1:0]  hz_slot_ff, nxt_hz_slot;
  // outputs
  gpr_write_t  gpr_ff, nxt_gpr;
  logic        pc_load_ff, nxt_pc_load;
  logic [31:0] pc_next_ff, nxt_pc_next;
  logic        isa_ff, nxt_isa;
  logic        addr_err_ff, nxt_addr_err;
  logic        hz_clr_ff, nxt_hz_clr;
  // apb
  logic        rdy_ff, nxt_rdy;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        err_ff, nxt_err;

  logic        acc_first;
  logic        wr_take;
  logic        mapped;
  logic        ctrl_wr;
  logic [31:0] status_word;
  logic [1:0]  hz_evt;
  jump_calc_t  calc;

  jump_target_calc u_calc (
    .instr    (instr_ff),
    .jump_pc  (jump_pc_ff),
    .src_val  (src_val_ff),
    .isa_now  (isa_ff),
    .dual_isa (dual_isa_ff),
    .calc     (calc)
  );

  // apb phase decode; one wait state lets read data come from a flop
  assign acc_first = psel & penable & ~rdy_ff;
  assign wr_take   = psel & penable & rdy_ff & pwrite & ~err_ff;
  assign ctrl_wr   = wr_take & (paddr == OFS_CTRL);
  assign hz_evt    = {hazard_instr_evt, hazard_exec_evt};

  // address map check
  always_comb begin
    // holes in the map are refused with pslverr
    case (paddr)
      OFS_CTRL, OFS_INSTR, OFS_JUMP_PC, OFS_SRC_VAL,
      OFS_STATUS, OFS_LINK_VAL, OFS_TARGET, OFS_RESUME: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // status word assembled from live state
  always_comb begin
    // unused bits read as zero so software may mask loosely
    status_word = '0;
    status_word[ST_STATE_LO +: 2] = state_ff;
    status_word[ST_KIND_LO +: 2]  = held_ff.kind;
    status_word[ST_ISA]           = isa_ff;
    status_word[ST_ADDR_ERR]      = addr_err_ff;
    status_word[ST_HZ_EXEC]       = hz_old_ff[0] | hz_slot_ff[0];
    status_word[ST_HZ_INSTR]      = hz_old_ff[1] | hz_slot_ff[1];
    status_word[ST_BAD_OP]        = bad_op_ff;
    status_word[ST_SAME_REG]      = held_ff.same_reg;
    status_word[ST_RESUMABLE]     = resumable_ff;
    status_word[ST_LINK_LO +: 5]  = held_ff.link_idx;
  end

  // apb handshake and read data
  always_comb begin
    nxt_rdy   = acc_first;
    nxt_rdata = rdata_ff;
    nxt_err   = err_ff;
    if (acc_first) begin
      nxt_err   = ~mapped;
      nxt_rdata = '0;
      // write cycles read back zero; spare control bits read as zero
      if (!pwrite) begin
        case (paddr)
          OFS_CTRL: begin
            nxt_rdata[CTRL_DUAL_ISA] = dual_isa_ff;
          end
          OFS_INSTR:    nxt_rdata = instr_ff;
          OFS_JUMP_PC:  nxt_rdata = jump_pc_ff;
          OFS_SRC_VAL:  nxt_rdata = src_val_ff;
          OFS_STATUS:   nxt_rdata = status_word;
          OFS_LINK_VAL: nxt_rdata = held_ff.link_val;
          OFS_TARGET:   nxt_rdata = held_ff.target;
          OFS_RESUME:   nxt_rdata = resume_ff;
          default:      nxt_rdata = '0;
        endcase
      end
    end
  end

  // software writes to the jump context; locked while a jump is in flight
  always_comb begin
    nxt_instr    = instr_ff;
    nxt_jump_pc  = jump_pc_ff;
    nxt_src_val  = src_val_ff;
    nxt_dual_isa = dual_isa_ff;
    // a jump in flight keeps its context so a slot fault can repeat it
    if (wr_take && state_ff == ST_IDLE) begin
      case (paddr)
        OFS_INSTR:   nxt_instr   = pwdata;
        OFS_JUMP_PC: nxt_jump_pc = pwdata;
        OFS_SRC_VAL: nxt_src_val = pwdata;
        OFS_CTRL:    nxt_dual_isa = pwdata[CTRL_DUAL_ISA];
        default:     nxt_instr   = instr_ff;
      endcase
    end
  end

  // sequencer: link at issue, wait for slot, then redirect
  always_comb begin
    nxt_state     = state_ff;
    nxt_held      = held_ff;
    nxt_resume    = resume_ff;
    nxt_bad_op    = bad_op_ff;
    nxt_resumable = resumable_ff;
    nxt_gpr       = '0;
    nxt_pc_load   = 1'b0;
    nxt_pc_next   = pc_next_ff;
    nxt_isa       = isa_ff;
    nxt_addr_err  = addr_err_ff;
    nxt_hz_clr    = 1'b0;
    // clear first, so a failed start in the same write still sets the flag
    if (ctrl_wr && pwdata[CTRL_CLR_BAD]) begin
      nxt_bad_op = 1'b0;
    end
    case (state_ff)
      ST_IDLE: begin
        if (ctrl_wr && pwdata[CTRL_START]) begin
          if (calc.kind == KIND_NONE) begin
            nxt_bad_op = 1'b1;
          end else begin
            // no privilege check on the barrier form
            nxt_held      = calc;
            nxt_resumable = 1'b0;
            nxt_addr_err  = 1'b0;
            // link written in the issue step
            nxt_gpr.en    = 1'b1;
            nxt_gpr.idx   = calc.link_idx;
            nxt_gpr.data  = calc.link_val;
            nxt_state     = ST_SLOT;
          end
        end
      end
      ST_SLOT: begin
        // slot assumed a single 16-bit instruction
        // slot fault returns to the jump address
        if (ctrl_wr && pwdata[CTRL_SLOT_EXC]) begin
          nxt_resume    = jump_pc_ff;
          nxt_resumable = 1'b1;
          nxt_state     = ST_IDLE;
        // transfer only once the slot retired
        end else if (ctrl_wr && pwdata[CTRL_SLOT_OK]) begin
          nxt_state = ST_XFER;
        end
      end
      ST_XFER: begin
        nxt_pc_load  = 1'b1;
        nxt_pc_next  = held_ff.target;
        nxt_isa      = held_ff.isa_sel;
        // error flagged with the redirected fetch
        // same flag for the single-set core
        nxt_addr_err = held_ff.addr_err;
        // clear before the target is fetched
        nxt_hz_clr   = (held_ff.kind == KIND_BARRIER);
        nxt_state    = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // hazard tracking; new events win over a clear in the same cycle
  always_comb begin
    nxt_hz_old  = hz_old_ff;
    nxt_hz_slot = hz_slot_ff;
    // events must never be lost to a barrier clear in the same cycle
    if (state_ff == ST_IDLE) begin
      // slot-born hazards fold into the ordinary pending set
      nxt_hz_old  = hz_old_ff | hz_slot_ff | hz_evt;
      nxt_hz_slot = 2'h0;
    end else begin
      // events after issue are kept apart
      nxt_hz_slot = hz_slot_ff | hz_evt;
      if (state_ff == ST_XFER && held_ff.kind == KIND_BARRIER) begin
        nxt_hz_old = 2'h0;
      end
    end
    // nothing but this barrier clear and a reset ever drops a hazard
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ff     <= '0;
      jump_pc_ff   <= RESET_ADDR;
      src_val_ff   <= '0;
      dual_isa_ff  <= 1'b0;
      resume_ff    <= RESET_ADDR;
      bad_op_ff    <= 1'b0;
      resumable_ff <= 1'b0;
      state_ff     <= ST_IDLE;
      held_ff      <= '0;
      hz_old_ff    <= 2'h0;
      hz_slot_ff   <= 2'h0;
      gpr_ff       <= '0;
      pc_load_ff   <= 1'b0;
      pc_next_ff   <= RESET_ADDR;
      // fetch restarts in the compact set, which every core has
      isa_ff       <= 1'b1;
      addr_err_ff  <= 1'b0;
      hz_clr_ff    <= 1'b0;
      rdy_ff       <= 1'b0;
      rdata_ff     <= '0;
      err_ff       <= 1'b0;
    end else begin
      instr_ff     <= nxt_instr;
      jump_pc_ff   <= nxt_jump_pc;
      src_val_ff   <= nxt_src_val;
      dual_isa_ff  <= nxt_dual_isa;
      resume_ff    <= nxt_resume;
      bad_op_ff    <= nxt_bad_op;
      resumable_ff <= nxt_resumable;
      state_ff     <= nxt_state;
      held_ff      <= nxt_held;
      hz_old_ff    <= nxt_hz_old;
      hz_slot_ff   <= nxt_hz_slot;
      gpr_ff       <= nxt_gpr;
      pc_load_ff   <= nxt_pc_load;
      pc_next_ff   <= nxt_pc_next;
      isa_ff       <= nxt_isa;
      addr_err_ff  <= nxt_addr_err;
      hz_clr_ff    <= nxt_hz_clr;
      rdy_ff       <= nxt_rdy;
      rdata_ff     <= nxt_rdata;
      err_ff       <= nxt_err;
    end
  end

  // output drive
  assign prdata         = rdata_ff;
  assign pready         = rdy_ff;
  // error only qualifies the cycle in which pready stands
  assign pslverr        = rdy_ff & err_ff;
  assign gpr_wr_en      = gpr_ff.en;
  assign gpr_wr_idx     = gpr_ff.idx;
  assign gpr_wr_data    = gpr_ff.data;
  assign pc_load        = pc_load_ff;
  assign pc_next        = pc_next_ff;
  assign isa_select_bit = isa_ff;
  assign fetch_addr_err = addr_err_ff;
  assign hazard_clear   = hz_clr_ff;

endmodule
`default_nettype wire

//--- verification/hazard_event_model.sv
// core-side model that raises hazard events on request
`timescale 1ns/1ps
`default_nettype none
module hazard_event_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // requests and events
  input  wire logic want_exec,
  input  wire logic want_instr,
  output logic      hazard_exec_evt,
  output logic      hazard_instr_evt
);
  // registered so each event is a clean one-cycle pulse after an edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hazard_exec_evt  <= 1'h0;
      hazard_instr_evt <= 1'h0;
    end else begin
      hazard_exec_evt  <= want_exec;
      hazard_instr_evt <= want_instr;
    end
  end
endmodule
`default_nettype wire

//--- verification/link_jump_assertions.sv
// port checker for the short-slot link jump unit
`timescale 1ns/1ps
`default_nettype none
module link_jump_assertions
  import link_jump_pkg::*;
(
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // jump results
  input wire logic        gpr_wr_en,
  input wire logic [4:0]  gpr_wr_idx,
  input wire logic [31:0] gpr_wr_data,
  input wire logic        pc_load,
  input wire logic [31:0] pc_next,
  input wire logic        isa_select_bit,
  input wire logic        fetch_addr_err,
  input wire logic        hazard_clear
);
  logic [31:0] ins_ff, pc_ff, src_ff, slot_pc;
  logic        dl_ff, wok, pool, bar, rgn;
  // shadow of the jump context; a write lands only at its pready edge
  assign wok = psel && penable && pready && pwrite;
  assign pool = ins_ff[31:26] == 6'h00 && ins_ff[5:0] == 6'h3C;
  assign bar = pool && ins_ff[15:6] == 10'h17C;
  assign rgn = ins_ff[31:26] == 6'h1D;
  assign slot_pc = pc_ff + 32'h4;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_ff <= '0;
      pc_ff  <= '0;
      src_ff <= '0;
      dl_ff  <= 1'h0;
    end else if (wok) begin
      if (paddr == OFS_INSTR) ins_ff <= pwdata;
      if (paddr == OFS_JUMP_PC) pc_ff <= pwdata;
      if (paddr == OFS_SRC_VAL) src_ff <= pwdata;
      if (paddr == OFS_CTRL) dl_ff <= pwdata[1];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_link; gpr_wr_en |-> gpr_wr_data == pc_ff + 32'h6; endproperty
  a_link: assert property (p_link) else $error("bad link value");
  property p_lidx; gpr_wr_en && pool |-> gpr_wr_idx == ins_ff[25:21]; endproperty
  a_lidx: assert property (p_lidx) else $error("bad link index");
  property p_r31; gpr_wr_en && rgn |-> gpr_wr_idx == 5'h1F; endproperty
  a_r31: assert property (p_r31) else $error("region link not r31");
  property p_go; wok && paddr == OFS_CTRL && pwdata[0] && rgn |-> ##[1:3] gpr_wr_en; endproperty
  a_go: assert property (p_go) else $error("region jump not issued");
  property p_xfer; wok && paddr == OFS_CTRL && pwdata[2] |-> ##[1:3] pc_load; endproperty
  a_xfer: assert property (p_xfer) else $error("no transfer after slot");
  property p_tgt; pc_load && pool |-> pc_next == {src_ff[31:1], 1'h0}; endproperty
  a_tgt: assert property (p_tgt) else $error("bad register target");
  property p_isa; pc_load && pool && dl_ff |-> isa_select_bit == src_ff[0]; endproperty
  a_isa: assert property (p_isa) else $error("bad mode bit");
  property p_ae2; pc_load && pool && dl_ff |-> fetch_addr_err == (!src_ff[0] && src_ff[1]);
  endproperty
  a_ae2: assert property (p_ae2) else $error("bad dual-set error");
  property p_ae1; pc_load && pool && !dl_ff |-> fetch_addr_err == !src_ff[0]; endproperty
  a_ae1: assert property (p_ae1) else $error("bad single-set error");
  property p_rgn; pc_load && rgn |-> pc_next == {slot_pc[31:27], ins_ff[25:0], 1'h0};
  endproperty
  a_rgn: assert property (p_rgn) else $error("bad region target");
  property p_hzc; pc_load |-> hazard_clear == bar; endproperty
  a_hzc: assert property (p_hzc) else $error("bad hazard clear");
  c_bar: cover property (pc_load && bar);
  c_rgn: cover property (pc_load && rgn);
  c_err: cover property (pc_load && fetch_addr_err);
endmodule
bind short_slot_link_jump_unit link_jump_assertions u_link_jump_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .gpr_wr_en(gpr_wr_en),
  .gpr_wr_idx(gpr_wr_idx), .gpr_wr_data(gpr_wr_data), .pc_load(pc_load),
  .pc_next(pc_next), .isa_select_bit(isa_select_bit), .fetch_addr_err(fetch_addr_err),
  .hazard_clear(hazard_clear)
);
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the short-slot link jump unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import link_jump_pkg::*;
  typedef struct {
    logic [31:0] ins, pc, src, tgt;
    logic        dl, isa, err, hz;
    logic [4:0]  idx;
  } row_t;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        wx = 1'h0;
  logic        wi = 1'h0;
  logic [31:0] prdata, pcn, gwd, g_d, rd_d;
  logic        pready, pslverr, hx, hi, gwe, pcl, isb, fae, hzc, rd_e;
  logic [4:0]  gwi, g_i;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          gw_n = 0;
  int          pl_n = 0;
  int          hz_n = 0;
  int          g0, p0, h0;
  // plain, barrier and region jumps; sources never equal links, two targets raise an address error
  // legal code
  row_t rows[6] = '{
    '{{6'h00,5'h05,5'h09,10'h13C,6'h3C},32'h1000,32'h1235,32'h1234,1,1,0,0,5'h05},
    '{{6'h00,5'h1F,5'h02,10'h13C,6'h3C},32'h8010,32'h2002,32'h2002,1,0,1,0,5'h1F},
    '{{6'h00,5'h03,5'h04,10'h17C,6'h3C},32'h10,32'h3000,32'h3000,0,1,1,1,5'h03},
    '{{6'h00,5'h07,5'h08,10'h17C,6'h3C},32'h7FFA,32'h4001,32'h4000,1,1,0,1,5'h07},
    '{{6'h1D,26'h0ABCDE},32'h0FFFFFFC,32'h0,32'h101579BC,1,1,0,0,5'h1F},
    '{{6'h00,5'h02,5'h06,10'h13C,6'h3C},32'h20,32'h5001,32'h5000,0,1,0,0,5'h02}};
  short_slot_link_jump_unit u_short_slot_link_jump_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hazard_exec_evt(hx), .hazard_instr_evt(hi), .gpr_wr_en(gwe), .gpr_wr_idx(gwi),
    .gpr_wr_data(gwd), .pc_load(pcl), .pc_next(pcn), .isa_select_bit(isb),
    .fetch_addr_err(fae), .hazard_clear(hzc));
  hazard_event_model u_hazard_event_model (
    .pclk(pclk), .presetn(presetn), .want_exec(wx), .want_instr(wi),
    .hazard_exec_evt(hx), .hazard_instr_evt(hi));
  always #50 pclk = ~pclk;
  // count pulses where they stand and keep the last link write
  always @(posedge pclk) begin
    if (gwe === 1'h1) begin
      gw_n <= gw_n + 1;
      g_i  <= gwi;
      g_d  <= gwd;
    end
    if (pcl === 1'h1) pl_n <= pl_n + 1;
    if (hzc === 1'h1) hz_n <= hz_n + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) begin
      error_cnt++;
      stop_test();
    end
    rd_d = prdata;
    rd_e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic launch(input logic [31:0] ins, pc, src, input logic dl);
    apb(1'h1, OFS_INSTR, ins);
    apb(1'h1, OFS_JUMP_PC, pc);
    apb(1'h1, OFS_SRC_VAL, src);
    apb(1'h1, OFS_CTRL, {30'h0, dl, 1'h0});
    apb(1'h1, OFS_CTRL, {30'h0, dl, 1'h1});
  endtask
  // slot holds a 16-bit plain op
  task automatic slot(input logic dl, input logic exc);
    apb(1'h1, OFS_CTRL, {28'h0, exc, !exc, dl, 1'h0});
    repeat (4) @(posedge pclk);
  endtask
  task automatic ev(input logic x, input logic i);
    wx <= x;
    wi <= i;
    @(posedge pclk);
    wx <= 1'h0;
    wi <= 1'h0;
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[k]) begin
      p0 = pl_n;
      h0 = hz_n;
      launch(rows[k].ins, rows[k].pc, rows[k].src, rows[k].dl);
      slot(rows[k].dl, 1'h0);
      chk("link idx", 32'(g_i), 32'(rows[k].idx));
      chk("link val", g_d, rows[k].pc + 32'h6);
      chk("target", pcn, rows[k].tgt);
      chk("isa", 32'(isb), 32'(rows[k].isa));
      chk("addr err", 32'(fae), 32'(rows[k].err));
      chk("loads", 32'(pl_n - p0), 32'h1);
      chk("hz clear", 32'(hz_n - h0), 32'(rows[k].hz));
    end
    apb(1'h0, OFS_LINK_VAL, 32'h0);
    chk("link reg", rd_d, rows[5].pc + 32'h6);
    apb(1'h0, OFS_TARGET, 32'h0);
    chk("target reg", rd_d, rows[5].tgt);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("kind", 32'(rd_d[3:2]), 32'h1);
    // fault in the slot, then the same jump is issued again
    g0 = gw_n;
    launch(rows[0].ins, rows[0].pc, rows[0].src, 1'h1);
    p0 = pl_n;
    slot(1'h1, 1'h1);
    chk("no load", 32'(pl_n - p0), 32'h0);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("resumable", 32'(rd_d[10]), 32'h1);
    apb(1'h0, OFS_RESUME, 32'h0);
    chk("resume pc", rd_d, rows[0].pc);
    apb(1'h1, OFS_CTRL, 32'h3);
    slot(1'h1, 1'h0);
    chk("relinks", 32'(gw_n - g0), 32'h2);
    chk("relink val", g_d, rows[0].pc + 32'h6);
    // hazards stay until a barrier; one raised in its slot survives it
    ev(1'h1, 1'h1);
    repeat (8) @(posedge pclk);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("hz kept", 32'(rd_d[7:6]), 32'h3);
    launch(rows[0].ins, rows[0].pc, rows[0].src, 1'h1);
    slot(1'h1, 1'h0);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("hz plain", 32'(rd_d[7:6]), 32'h3);
    launch(rows[3].ins, rows[3].pc, rows[3].src, 1'h1);
    ev(1'h1, 1'h0);
    slot(1'h1, 1'h0);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("hz slot", 32'(rd_d[7:6]), 32'h1);
    // wrong sub-pool code is not a jump
    g0 = gw_n;
    launch({6'h00, 5'h05, 5'h09, 10'h13C, 6'h3D}, 32'h40, 32'h80, 1'h1);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("bad op", 32'(rd_d[8]), 32'h1);
    chk("no link", 32'(gw_n - g0), 32'h0);
    apb(1'h0, OFS_CTRL, 32'h0);
    chk("ctrl dual", rd_d, 32'h2);
    apb(1'h1, OFS_CTRL, 32'h12);
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("bad op clr", 32'(rd_d[8]), 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk("slverr", 32'(rd_e), 32'h1);
    chk("unmapped", rd_d, 32'h0);
    // second reset in mid-run
    presetn <= 1'h0;
    repeat (5) @(posedge pclk);
    chk("rst isa", 32'(isb), 32'h1);
    chk("rst load", 32'(pcl), 32'h0);
    presetn <= 1'h1;
    apb(1'h0, OFS_STATUS, 32'h0);
    chk("rst hz", 32'(rd_d[7:6]), 32'h0);
    stop_test();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
